// >>> core/scf_defs.svh
// Purpose: constants for the dual-clock 9-bit FIFO core
// Assumes: included by bare name from the design file
// Notes: depth must stay a power of two for pointer wrap
`ifndef SCF_DEFS_SVH
`define SCF_DEFS_SVH

`define SCF_WIDTH 9
`define SCF_DEPTH 64
`define SCF_AW 6
`define SCF_PW 7
`define SCF_DEPTH_P 7'h40
`define SCF_STAGE_DEPTH 8
`define SCF_OFS_N 4
`define SCF_OFS_EMPTY_LO 2'h0
`define SCF_OFS_EMPTY_HI 2'h1
`define SCF_OFS_FULL_LO 2'h2
`define SCF_OFS_FULL_HI 2'h3
`define SCF_OFS_LO_RST 8'h07
`define SCF_OFS_HI_RST 8'h00
`define SCF_SYNC_W 17

`endif

// >>> core/scf_pkg.sv
// Purpose: shared types of the dual-clock 9-bit FIFO core
// Assumes: nothing
// Notes: mode is latched while the reset pin is low
package scf_pkg;
    typedef enum logic {SCF_MODE_TWO_EN, SCF_MODE_PROG} scf_mode_t;
endpackage : scf_pkg

// >>> core/scf_fifo_top.sv
// Purpose: dual-clock 9-bit FIFO with empty, full and programmable flags
// Assumes: pin clocks well below core_clk_in / 2, so each edge is seen
// Notes: every pin input passes a two-flop synchroniser on core_clk_in
// Function
// - reset pin low samples second enable: high two-enable, low offset load
// - two-enable write needs primary low, second high, full flag high
// - programmable mode writes while primary enable is low and load is high
// - writes while full are dropped; memory and pointer unchanged
// - read edge with both read enables low and not empty pops a word
// - load low and primary low writes selected offset register
// - load low and both read enables low outputs selected offset register, unless an offset write lands in the same cycle
// - empty flags change only on read edges; empty low when no words
// - full flags change only on write edges; full low when all used
// - almost-empty low when count at or below empty offset
// - almost-full low when free space within full offset
// - both offsets default to seven after reset
// - each flag holds its value at least one governing clock cycle
// - reset clears both pointers and drives empty flag low
// - reset drives data outputs low and flags to reset state
// - output enable low drives outputs, high releases them
// - reads while empty ignored; outputs keep last word
// - writes sequential and independent of reads; clocks may be tied
// - array of 64 to 8K words of 9 bits, separate pointers; this core builds the 64-word array only
// - four 8-bit offset registers: empty lo/hi, full lo/hi
// - offset accesses step in sequence and wrap; pointer kept
// - almost-empty high on read edge once count exceeds offset
// - almost-full high on write edge when free exceeds full offset
`include "scf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module scf_stage_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic flush_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] head_r;
    logic [AW-1:0] tail_r;
    logic [AW:0] cnt_r;
    wire push = in_valid_in & in_ready_out;
    wire pop = out_valid_out & out_ready_in;

    assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out = mem_r[head_r];

    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_r[tail_r] <= in_data_in;
    end

    // index wrap relies on a power-of-two depth
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            head_r <= '0;
            tail_r <= '0;
            cnt_r <= '0;
        end
        else if (flush_in)
        begin
            head_r <= '0;
            tail_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            head_r <= head_r + AW'(pop);
            tail_r <= tail_r + AW'(push);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : scf_stage_fifo

module scf_fifo_top (
    // core clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // pin clocks and reset
    input wire logic wclk_in,
    input wire logic rclk_in,
    input wire logic reset_n_in,
    // write side pins
    input wire logic [8:0] data_in,
    input wire logic write_enable_primary_n_in,
    input wire logic write_enable_second_or_load_in,
    // read side pins
    input wire logic read_enable_a_n_in,
    input wire logic read_enable_b_n_in,
    input wire logic output_enable_n_in,
    output logic [8:0] data_out,
    output logic data_out_en_out,
    // flags
    output logic empty_flag_n_out,
    output logic almost_empty_flag_n_out,
    output logic full_flag_n_out,
    output logic almost_full_flag_n_out
);
    function automatic logic [`SCF_PW-1:0] bin2gray(
        input logic [`SCF_PW-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [`SCF_PW-1:0] gray2bin(
        input logic [`SCF_PW-1:0] g);
        logic [`SCF_PW-1:0] b;
        b = g;
        for (int i = `SCF_PW - 2; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        gray2bin = b;
    endfunction : gray2bin

    logic [`SCF_SYNC_W-1:0] pin_s1_r;
    logic [`SCF_SYNC_W-1:0] pin_s2_r;
    logic wclk_s3_r;
    logic rclk_s3_r;
    scf_pkg::scf_mode_t mode_r;
    logic [`SCF_WIDTH-1:0] mem_r [`SCF_DEPTH];
    logic [`SCF_PW-1:0] wptr_r;
    logic [`SCF_PW-1:0] cptr_r;
    logic [`SCF_PW-1:0] rptr_r;
    logic [`SCF_PW-1:0] cptr_gray_r;
    logic [`SCF_PW-1:0] rptr_gray_r;
    logic [`SCF_PW-1:0] cg_s1_r;
    logic [`SCF_PW-1:0] cg_s2_r;
    logic [`SCF_PW-1:0] rg_s1_r;
    logic [`SCF_PW-1:0] rg_s2_r;
    logic [7:0] ofs_r [`SCF_OFS_N];
    logic [1:0] sel_r;

    // synchronised pins
    wire wclk_s = pin_s2_r[16];
    wire rclk_s = pin_s2_r[15];
    wire rs_active = ~pin_s2_r[14];
    wire write_enable_primary_n_n = pin_s2_r[13];
    wire second_hi = pin_s2_r[12];
    wire ren_a_n = pin_s2_r[11];
    wire ren_b_n = pin_s2_r[10];
    wire oe_n = pin_s2_r[9];
    wire [8:0] din = pin_s2_r[8:0];
    wire wr_edge = wclk_s & ~wclk_s3_r;
    wire rd_edge = rclk_s & ~rclk_s3_r;

    // decode of the pin requests
    wire load_act = (mode_r == scf_pkg::SCF_MODE_PROG) & ~second_hi;
    wire stage_ready;
    wire stage_valid;
    wire [8:0] stage_data;
    wire fifo_wr = wr_edge & ~rs_active & ~write_enable_primary_n_n & second_hi
        & full_flag_n_out & stage_ready;
    wire ofs_wr = wr_edge & ~rs_active & ~write_enable_primary_n_n & load_act;
    wire rd_req = rd_edge & ~rs_active & ~ren_a_n & ~ren_b_n;
    wire ofs_rd = rd_req & load_act & ~ofs_wr;
    wire fifo_rd = rd_req & ~load_act & empty_flag_n_out;
    // one-port array model: a pop steals the cycle from the drain
    wire drain = stage_valid & ~fifo_rd;

    // flag arithmetic
    wire [`SCF_PW-1:0] wptr_nxt = wptr_r + `SCF_PW'(fifo_wr);
    wire [`SCF_PW-1:0] rptr_nxt = rptr_r + `SCF_PW'(fifo_rd);
    wire [`SCF_PW-1:0] wr_used = wptr_nxt - gray2bin(rg_s2_r);
    wire [`SCF_PW-1:0] wr_free = `SCF_DEPTH_P - wr_used;
    wire [`SCF_PW-1:0] rd_used = gray2bin(cg_s2_r) - rptr_nxt;
    wire [15:0] empty_ofs = {ofs_r[`SCF_OFS_EMPTY_HI],
        ofs_r[`SCF_OFS_EMPTY_LO]};
    wire [15:0] full_ofs = {ofs_r[`SCF_OFS_FULL_HI], ofs_r[`SCF_OFS_FULL_LO]};
    wire full_n_nxt = (wr_used != `SCF_DEPTH_P);
    wire afull_n_nxt = ({9'h000, wr_free} > full_ofs);
    wire empty_n_nxt = (rd_used != `SCF_PW'(0));
    wire aempty_n_nxt = ({9'h000, rd_used} > empty_ofs);

    // small staging buffer; its ready gates the write acceptance
    scf_stage_fifo #(
        .WIDTH(`SCF_WIDTH),
        .DEPTH(`SCF_STAGE_DEPTH)
    ) u_stage (
        .clk_in(core_clk_in),
        .rstn_in(resetn_in),
        .flush_in(rs_active),
        .in_valid_in(fifo_wr),
        .in_ready_out(stage_ready),
        .in_data_in(din),
        .out_valid_out(stage_valid),
        .out_ready_in(~fifo_rd),
        .out_data_out(stage_data)
    );

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            wclk_s3_r <= 1'b0;
            rclk_s3_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= {wclk_in, rclk_in, reset_n_in,
                write_enable_primary_n_in, write_enable_second_or_load_in,
                read_enable_a_n_in, read_enable_b_n_in, output_enable_n_in,
                data_in};
            pin_s2_r <= pin_s1_r;
            wclk_s3_r <= wclk_s;
            rclk_s3_r <= rclk_s;
        end
    end

    // mode strap caught from the synchronised pin while reset is low
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            mode_r <= scf_pkg::SCF_MODE_TWO_EN;
        else if (rs_active)
            mode_r <= second_hi ? scf_pkg::SCF_MODE_TWO_EN
                : scf_pkg::SCF_MODE_PROG;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (drain)
            mem_r[cptr_r[`SCF_AW-1:0]] <= stage_data;
    end

    // pointers; write slot reserved at acceptance, committed at drain
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wptr_r <= '0;
            cptr_r <= '0;
            rptr_r <= '0;
        end
        else if (rs_active)
        begin
            wptr_r <= '0;
            cptr_r <= '0;
            rptr_r <= '0;
        end
        else
        begin
            wptr_r <= wptr_nxt;
            cptr_r <= cptr_r + `SCF_PW'(drain);
            rptr_r <= rptr_nxt;
        end
    end

    // gray copies are registered so the crossing never sees a glitch
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cptr_gray_r <= '0;
            rptr_gray_r <= '0;
            cg_s1_r <= '0;
            cg_s2_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end
        else
        begin
            cptr_gray_r <= bin2gray(cptr_r);
            rptr_gray_r <= bin2gray(rptr_r);
            cg_s1_r <= cptr_gray_r;
            cg_s2_r <= cg_s1_r;
            rg_s1_r <= rptr_gray_r;
            rg_s2_r <= rg_s1_r;
        end
    end

    // offset registers and their shared selection pointer
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ofs_r[`SCF_OFS_EMPTY_LO] <= `SCF_OFS_LO_RST;
            ofs_r[`SCF_OFS_EMPTY_HI] <= `SCF_OFS_HI_RST;
            ofs_r[`SCF_OFS_FULL_LO] <= `SCF_OFS_LO_RST;
            ofs_r[`SCF_OFS_FULL_HI] <= `SCF_OFS_HI_RST;
            sel_r <= `SCF_OFS_EMPTY_LO;
        end
        else if (rs_active)
        begin
            ofs_r[`SCF_OFS_EMPTY_LO] <= `SCF_OFS_LO_RST;
            ofs_r[`SCF_OFS_EMPTY_HI] <= `SCF_OFS_HI_RST;
            ofs_r[`SCF_OFS_FULL_LO] <= `SCF_OFS_LO_RST;
            ofs_r[`SCF_OFS_FULL_HI] <= `SCF_OFS_HI_RST;
            sel_r <= `SCF_OFS_EMPTY_LO;
        end
        else
        begin
            if (ofs_wr)
                ofs_r[sel_r] <= din[7:0];
            if (ofs_wr | ofs_rd)
                sel_r <= sel_r + 2'h1;
        end
    end

    // outputs and flags, each flag moved only by its own side's edge
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            data_out <= '0;
            data_out_en_out <= 1'b0;
            empty_flag_n_out <= 1'b0;
            almost_empty_flag_n_out <= 1'b0;
            full_flag_n_out <= 1'b1;
            almost_full_flag_n_out <= 1'b1;
        end
        else
        begin
            data_out_en_out <= ~oe_n;
            if (rs_active)
            begin
                data_out <= '0;
                empty_flag_n_out <= 1'b0;
                almost_empty_flag_n_out <= 1'b0;
                full_flag_n_out <= 1'b1;
                almost_full_flag_n_out <= 1'b1;
            end
            else
            begin
                if (fifo_rd)
                    data_out <= mem_r[rptr_r[`SCF_AW-1:0]];
                else if (ofs_rd)
                    data_out <= {1'b0, ofs_r[sel_r]};
                if (rd_edge)
                begin
                    empty_flag_n_out <= empty_n_nxt;
                    almost_empty_flag_n_out <= aempty_n_nxt;
                end
                if (wr_edge)
                begin
                    full_flag_n_out <= full_n_nxt;
                    almost_full_flag_n_out <= afull_n_nxt;
                end
            end
        end
    end

    a_full_drops_write: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (!full_flag_n_out && !rs_active) |=> $stable(wptr_r))
        else $error("write accepted while full");

    a_empty_keeps_out: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (rd_edge && !empty_flag_n_out && !load_act && !rs_active)
        |=> $stable(data_out) && $stable(rptr_r))
        else $error("read taken while empty");

    a_empty_on_redge: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        $changed(empty_flag_n_out) |-> $past(rd_edge || rs_active))
        else $error("empty flag moved without read edge");

    a_full_on_wedge: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        $changed(almost_full_flag_n_out) |-> $past(wr_edge || rs_active))
        else $error("almost full moved without write edge");

    a_flag_holds: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        ($changed(full_flag_n_out) && !rs_active) |=> $stable(full_flag_n_out))
        else $error("full flag changed twice in a row");

    a_reset_clears: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        rs_active |=> (wptr_r == '0) && (rptr_r == '0) && (data_out == '0)
        && !empty_flag_n_out)
        else $error("pin reset did not clear the fifo");

    a_ofs_default: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        rs_active |=> (empty_ofs == 16'h0007) && (full_ofs == 16'h0007))
        else $error("offsets not at default after reset");

    a_ofs_sel_step: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (ofs_wr || ofs_rd) |=> (sel_r == $past(sel_r) + 2'h1))
        else $error("offset pointer did not advance");

    a_oe_drive: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        (!oe_n && !rs_active) |=> data_out_en_out)
        else $error("outputs not driven with enable low");
endmodule : scf_fifo_top

`default_nettype wire

// >>> tb/scf_pin_agent.sv
// Purpose: writer and reader logic on the FIFO pin side
// Assumes: pin clock phases of 5 or more core cycles, above the 3 needed
// Notes: released data lines carry the inverse of the last word
`timescale 1ns/1ps
`default_nettype none

module scf_pin_agent (
    // core clock
    input wire logic clk_in,
    // pin drives
    output logic wclk_out,
    output logic rclk_out,
    output logic reset_n_out,
    output logic [8:0] wdata_out,
    output logic wen_p_n_out,
    output logic wen_s_ld_out,
    output logic ren_a_n_out,
    output logic ren_b_n_out
);
    initial
    begin
        wclk_out = 1'b0;
        rclk_out = 1'b0;
        // idle high so the first pin reset is a real falling edge
        reset_n_out = 1'b1;
        wdata_out = 9'h000;
        wen_p_n_out = 1'b1;
        wen_s_ld_out = 1'b1;
        ren_a_n_out = 1'b1;
        ren_b_n_out = 1'b1;
    end

    // strap held stable and no access while reset pin is low
    task pin_reset(input logic strap);
        @(posedge clk_in);
        reset_n_out <= 1'b0;
        wen_s_ld_out <= strap;
        repeat (6) @(posedge clk_in);
        reset_n_out <= 1'b1;
        repeat (4) @(posedge clk_in);
    endtask : pin_reset

    task wr_edge(input logic [8:0] d, input logic p_n, input logic s_ld);
        @(posedge clk_in);
        wdata_out <= d;
        wen_p_n_out <= p_n;
        wen_s_ld_out <= s_ld;
        repeat (4) @(posedge clk_in);
        wclk_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        wclk_out <= 1'b0;
        wdata_out <= ~d;
        wen_p_n_out <= 1'b1;
        @(negedge clk_in);
    endtask : wr_edge

    task rd_edge(input logic a_n, input logic b_n);
        @(posedge clk_in);
        ren_a_n_out <= a_n;
        ren_b_n_out <= b_n;
        repeat (4) @(posedge clk_in);
        rclk_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        rclk_out <= 1'b0;
        ren_a_n_out <= 1'b1;
        ren_b_n_out <= 1'b1;
        @(negedge clk_in);
    endtask : rd_edge
endmodule : scf_pin_agent

`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the dual-clock FIFO core
// Assumes: flags read after an own-side pin edge has refreshed them
// Notes: flag vectors are packed as empty, aempty, afull, full
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic oe_n = 1'b0;
    wire logic wclk, rclk, pin_rst_n, wen_p_n, wen_s_ld, ren_a_n, ren_b_n;
    wire logic [8:0] wdata;
    logic [8:0] q;
    logic q_en, ef_n, aef_n, ff_n, aff_n;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2.5 core_clk_in = ~core_clk_in;

    scf_pin_agent agent (.clk_in(core_clk_in), .wclk_out(wclk),
        .rclk_out(rclk), .reset_n_out(pin_rst_n), .wdata_out(wdata),
        .wen_p_n_out(wen_p_n), .wen_s_ld_out(wen_s_ld),
        .ren_a_n_out(ren_a_n), .ren_b_n_out(ren_b_n));

    scf_fifo_top uut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .wclk_in(wclk), .rclk_in(rclk), .reset_n_in(pin_rst_n),
        .data_in(wdata), .write_enable_primary_n_in(wen_p_n),
        .write_enable_second_or_load_in(wen_s_ld),
        .read_enable_a_n_in(ren_a_n), .read_enable_b_n_in(ren_b_n),
        .output_enable_n_in(oe_n), .data_out(q), .data_out_en_out(q_en),
        .empty_flag_n_out(ef_n), .almost_empty_flag_n_out(aef_n),
        .full_flag_n_out(ff_n), .almost_full_flag_n_out(aff_n));

    task results;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    task chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task chk_flags(input string name, input logic [3:0] exp);
        chk(name, {5'h00, exp}, {5'h00, ef_n, aef_n, aff_n, ff_n});
    endtask : chk_flags

    // extra wait lets the write pointer cross before the edge
    task idle_rd;
        repeat (4) @(posedge core_clk_in);
        agent.rd_edge(1'b1, 1'b1);
    endtask : idle_rd

    task t_reset;
        @(negedge core_clk_in);
        chk_flags("reset flags", 4'h3);
        chk("reset data", 9'h000, q);
        chk("drive en", 9'h001, {8'h00, q_en});
        @(posedge core_clk_in);
        oe_n <= 1'b1;
        // two sync flops plus the enable flop
        repeat (4) @(negedge core_clk_in);
        chk("release en", 9'h000, {8'h00, q_en});
        @(posedge core_clk_in);
        oe_n <= 1'b0;
    endtask : t_reset

    task t_two_en;
        int i;
        agent.wr_edge(9'h1AA, 1'b1, 1'b1);
        agent.wr_edge(9'h155, 1'b0, 1'b0);
        idle_rd();
        chk_flags("gated writes", 4'h3);
        for (i = 0; i < 64; i++)
        begin
            agent.wr_edge(9'(i) ^ 9'h0A5, 1'b0, 1'b1);
            chk("full side", {7'h00, 1'(63 - i > 7), 1'(i != 63)},
                {7'h00, aff_n, ff_n});
        end
        agent.wr_edge(9'h1FF, 1'b0, 1'b1);
        agent.rd_edge(1'b0, 1'b1);
        chk("no pop", 9'h000, q);
        chk_flags("full idle", 4'hC);
        for (i = 0; i < 64; i++)
        begin
            agent.rd_edge(1'b0, 1'b0);
            chk("read word", 9'(i) ^ 9'h0A5, q);
            if (i == 55 || i == 56)
            begin
                agent.rd_edge(1'b1, 1'b1);
                chk("aempty", {8'h00, 1'(i == 55)},
                    {8'h00, aef_n});
            end
        end
        agent.rd_edge(1'b1, 1'b1);
        chk_flags("drained", 4'h0);
        agent.rd_edge(1'b0, 1'b0);
        chk("empty read", 9'h03F ^ 9'h0A5, q);
        agent.wr_edge(9'h123, 1'b1, 1'b1);
        chk("full clear", 9'h003, {7'h00, aff_n, ff_n});
    endtask : t_two_en

    task t_prog;
        int i;
        for (i = 0; i < 4; i++)
        begin
            agent.rd_edge(1'b0, 1'b0);
            chk("default ofs", i[0] ? 9'h000 : 9'h007, q);
        end
        agent.wr_edge(9'h103, 1'b0, 1'b0);
        agent.wr_edge(9'h000, 1'b0, 1'b0);
        agent.wr_edge(9'h005, 1'b0, 1'b0);
        agent.wr_edge(9'h000, 1'b0, 1'b0);
        idle_rd();
        chk_flags("no fifo load", 4'h3);
        agent.rd_edge(1'b0, 1'b0);
        chk("empty lo", 9'h003, q);
        agent.rd_edge(1'b0, 1'b0);
        agent.wr_edge(9'h0AA, 1'b1, 1'b1);
        agent.wr_edge(9'h0AA, 1'b1, 1'b0);
        agent.rd_edge(1'b0, 1'b0);
        chk("kept pointer", 9'h005, q);
        agent.rd_edge(1'b0, 1'b0);
        for (i = 0; i < 59; i++)
        begin
            agent.wr_edge(9'(i) + 9'h011, 1'b0, 1'b1);
            if (i == 2 || i == 3)
            begin
                idle_rd();
                chk_flags("prog aempty",
                    i == 2 ? 4'hB : 4'hF);
            end
            if (i >= 57)
                chk("prog afull", {8'h00, 1'(i == 57)},
                    {8'h00, aff_n});
        end
    endtask : t_prog

    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            errors++;
            $display("[ERR] timeout expected done seen running");
            results();
        end
    end

    initial
    begin
        repeat (5) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        agent.pin_reset(1'b1);
        t_reset();
        t_two_en();
        agent.pin_reset(1'b0);
        t_prog();
        results();
    end
endmodule : tb_top

`default_nettype wire
